// *** design/tc_core.sv ***
`timescale 1ns/1ns
`include "tc_defs.svh"

// Notes on behaviour
// - Overflow flag set on each count overflow outside baud use; only software clears it.
// - Overflow flag is not set while either baud select bit is set.
// - A set external-event flag raises the timer interrupt request.
// - Each baud select picks this timer's overflow over the other timer's.
// - Counter select picks internal clock divided by six (by two in baud or clock-out use) or count-pin falling edges.
// - Clock-output enable makes the shared pin drive the generated clock.
// - Up/down enable lets the trigger pin level set direction outside capture mode and baud use; high is up.
// - Counting up, overflow at all ones loads the reload value, except in capture mode, where the count wraps to zero.
// - Upper six mode bits are reserved; software must write them as zero.
// - Control register resets to zero and accepts single-bit set and clear.
// - Mode register resets its low two bits and takes whole bytes only.
// - Count high byte is readable and writable; resets to zero.
module tc_core
  import tc_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic      [7:0]  sfr_rdata_o,
  input  wire logic        bit_wr_i,
  input  wire logic [7:0]  bit_addr_i,
  input  wire logic        bit_val_i,
  input  wire logic        external_count_pin_i,
  output logic             external_count_pin_o,
  output logic             external_count_pin_oe_o,
  input  wire logic        trigger_direction_pin_i,
  input  wire logic [15:0] reload_value_i,
  input  wire logic        count_low_wr_i,
  input  wire logic [7:0]  count_low_wdata_i,
  output logic      [7:0]  count_low_o,
  output logic             capture_o,
  output logic      [15:0] capture_value_o,
  output logic             timer_ovf_o,
  input  wire logic        timer1_ovf_i,
  output logic             rx_baud_clk_o,
  output logic             tx_baud_clk_o,
  output logic             timer_irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  ctrl;
  logic [1:0]  mode_bits;
  logic [15:0] count;
  logic [7:0]  sw_ctrl;
  logic [7:0]  next_ctrl;
  logic [15:0] next_count;
  tc_mode_type mode;
  tc_tick_if   evt();

  logic wr_ctrl;
  logic wr_mode;
  logic wr_cnth;
  logic bit_hit;
  logic run;
  logic dir_up;
  logic step;
  logic ovf_evt;
  logic trig_evt;

  assign mode     = tc_decode_mode(ctrl, mode_bits);
  assign run      = ctrl[`TC_RUN_BIT];
  assign wr_ctrl  = sfr_wr_i && (sfr_addr_i == `TC_CTRL_ADDR);
  assign wr_mode  = sfr_wr_i && (sfr_addr_i == `TC_MODE_ADDR);
  assign wr_cnth  = sfr_wr_i && (sfr_addr_i == `TC_CNTH_ADDR);
  assign bit_hit  = bit_wr_i && (bit_addr_i[7:3] == 5'(`TC_BIT_BASE >> 3));

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  // Baud and clock-out use count at the fast internal rate
  assign evt.counter_select = ctrl[`TC_CSEL_BIT];
  assign evt.fast = (mode == TC_BAUD) || (mode_bits[`TC_CLKOUT_BIT] && !ctrl[`TC_CSEL_BIT]);

  tc_tick_gen u_tick_gen
  (
    .clock_i                 (clock_i),
    .sys_rst_i               (sys_rst_i),
    .evt                     (evt),
    .external_count_pin_i    (external_count_pin_i),
    .trigger_direction_pin_i (trigger_direction_pin_i)
  );

  assign dir_up   = (mode != TC_UPDOWN) || trigger_direction_pin_i;
  assign step     = evt.tick && run;
  assign ovf_evt  = step && (dir_up ? (count == `TC_COUNT_MAX) : (count == reload_value_i));
  // Up/down mode ignores the trigger enable, the pin only steers direction
  assign trig_evt = evt.trig_fall && ctrl[`TC_TRGEN_BIT] && (mode != TC_UPDOWN);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_comb
  begin
    sw_ctrl = ctrl;
    if (wr_ctrl)
      sw_ctrl = sfr_wdata_i;
    if (bit_hit)
      sw_ctrl[bit_addr_i[2:0]] = bit_val_i;
  end

  // Hardware sets win over a software clear in the same cycle
  always_comb
  begin
    next_ctrl = sw_ctrl;
    if (ovf_evt && (mode != TC_BAUD))
      next_ctrl[`TC_OVF_BIT] = 1'b1;
    if (mode == TC_UPDOWN)
    begin
      if (ovf_evt)
        next_ctrl[`TC_EXT_BIT] = ~ctrl[`TC_EXT_BIT];
    end
    else if (trig_evt)
      next_ctrl[`TC_EXT_BIT] = 1'b1;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      ctrl <= `TC_CTRL_RESET;
    else
      ctrl <= next_ctrl;
  end

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  // Reserved bits are not stored, so they read back as zero
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      mode_bits <= `TC_MODE_RESET;
    else if (wr_mode)
      mode_bits <= sfr_wdata_i[1:0];
  end

  // ----------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------
  always_comb
  begin
    next_count = count;
    if (step)
    begin
      unique case (mode)
        TC_CAPTURE:
          next_count = count + 16'h0001;
        TC_RELOAD, TC_BAUD:
          next_count = ovf_evt ? reload_value_i : count + 16'h0001;
        TC_UPDOWN:
          if (dir_up)
            next_count = ovf_evt ? reload_value_i : count + 16'h0001;
          else
            next_count = ovf_evt ? `TC_COUNT_MAX : count - 16'h0001;
      endcase
    end
    if (trig_evt && (mode == TC_RELOAD))
      next_count = reload_value_i;
    // Software writes override the count in the cycle they land
    if (wr_cnth)
      next_count[15:8] = sfr_wdata_i;
    if (count_low_wr_i)
      next_count[7:0] = count_low_wdata_i;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      count <= `TC_COUNT_RESET;
    else
      count <= next_count;
  end

  assign count_low_o = count[7:0];

  // ----------------------------------------------------------------
  // Capture and overflow outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      capture_o       <= 1'b0;
      capture_value_o <= `TC_COUNT_RESET;
    end
    else
    begin
      capture_o <= trig_evt && (mode == TC_CAPTURE);
      if (trig_evt && (mode == TC_CAPTURE))
        capture_value_o <= count;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      timer_ovf_o <= 1'b0;
    else
      timer_ovf_o <= ovf_evt;
  end

  assign rx_baud_clk_o = ctrl[`TC_RXSEL_BIT] ? timer_ovf_o : timer1_ovf_i;
  assign tx_baud_clk_o = ctrl[`TC_TXSEL_BIT] ? timer_ovf_o : timer1_ovf_i;
  assign timer_irq_o   = ctrl[`TC_OVF_BIT] || ctrl[`TC_EXT_BIT];

  // ----------------------------------------------------------------
  // Clock output pin
  // ----------------------------------------------------------------
  tc_clk_out u_clk_out
  (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .enable_i  (mode_bits[`TC_CLKOUT_BIT]),
    .toggle_i  (ovf_evt),
    .pin_o     (external_count_pin_o)
  );

  assign external_count_pin_oe_o = mode_bits[`TC_CLKOUT_BIT];

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  // Read data lands one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        `TC_CTRL_ADDR: sfr_rdata_o <= ctrl;
        `TC_MODE_ADDR: sfr_rdata_o <= {6'h00, mode_bits};
        `TC_CNTH_ADDR: sfr_rdata_o <= count[15:8];
        default:       sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic sw_touch;
  assign sw_touch = wr_ctrl || bit_hit;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_ovf_flag_set: assert property (ovf_evt && (mode != TC_BAUD) |=> ctrl[`TC_OVF_BIT])
    else $error("overflow flag not set on overflow");

  a_ovf_flag_sticky: assert property (ctrl[`TC_OVF_BIT] && !sw_touch |=> ctrl[`TC_OVF_BIT])
    else $error("overflow flag cleared by hardware");

  a_baud_no_flag: assert property ((mode == TC_BAUD) && !ctrl[`TC_OVF_BIT] && !sw_touch |=> !ctrl[`TC_OVF_BIT])
    else $error("overflow flag set in baud use");

  a_irq_request: assert property (ctrl[`TC_EXT_BIT] |-> timer_irq_o)
    else $error("event flag without interrupt request");

  a_trig_ignored: assert property (!ctrl[`TC_TRGEN_BIT] |=> !capture_o)
    else $error("capture with trigger disabled");

  a_baud_source: assert property (ctrl[`TC_RXSEL_BIT] && !sw_touch |=> rx_baud_clk_o == timer_ovf_o)
    else $error("receive clock source wrong");

  a_run_hold: assert property (!run && !wr_cnth && !count_low_wr_i && !trig_evt |=> $stable(count))
    else $error("count moved while stopped");

  a_capture_value: assert property (trig_evt && (mode == TC_CAPTURE)
                                    |=> capture_o && (capture_value_o == $past(count)))
    else $error("capture missed or wrong value");

  // Configuration must stay put for the whole gap, else the rate legally changes
  a_timer_rate: assert property (evt.tick && !ctrl[`TC_CSEL_BIT] && !evt.fast && !sw_touch && !wr_mode
                                 ##1 (!sw_touch && !wr_mode) [*5]
                                 |-> !evt.tick && !$past(evt.tick, 1) && !$past(evt.tick, 2)
                                     && !$past(evt.tick, 3) && !$past(evt.tick, 4) ##1 evt.tick)
    else $error("internal tick not every sixth clock");

  a_pin_drive: assert property (external_count_pin_oe_o && !wr_mode
                                |=> external_count_pin_oe_o
                                    && (external_count_pin_o == ($past(external_count_pin_o) ^ $past(ovf_evt))))
    else $error("clock output pin did not follow overflows");

  a_down_step: assert property ((mode == TC_UPDOWN) && step && !dir_up && !ovf_evt
                                && !wr_cnth && !count_low_wr_i
                                |=> count == $past(count) - 16'h0001)
    else $error("down count step wrong");

  a_up_reload: assert property (ovf_evt && dir_up && (mode != TC_CAPTURE) && !wr_cnth && !count_low_wr_i
                                |=> count == $past(reload_value_i))
    else $error("reload on overflow missing");

  a_mode_read: assert property (sfr_rd_i && (sfr_addr_i == `TC_MODE_ADDR) |=> sfr_rdata_o[7:2] == 6'h00)
    else $error("reserved mode bits read nonzero");

  a_bit_access: assert property (bit_hit && !wr_ctrl && bit_addr_i[2:0] == 3'h2 |=> run == $past(bit_val_i))
    else $error("bit access to run bit lost");

  a_high_write: assert property (wr_cnth |=> count[15:8] == $past(sfr_wdata_i))
    else $error("high byte write lost");

  c_capture: cover property (capture_o);
  c_underflow: cover property ((mode == TC_UPDOWN) && ovf_evt && !dir_up);
  c_clock_out: cover property (external_count_pin_oe_o && $rose(external_count_pin_o));
  c_baud_ovf: cover property ((mode == TC_BAUD) && timer_ovf_o);

endmodule

// *** design/tc_defs.svh ***
`ifndef TC_DEFS_SVH
`define TC_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define TC_CTRL_ADDR   8'hC8
`define TC_MODE_ADDR   8'hC9
`define TC_CNTH_ADDR   8'hCD
// Bit addresses of the control register are base + bit index
`define TC_BIT_BASE    8'hC8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TC_CTRL_RESET  8'h00
`define TC_MODE_RESET  2'h0
`define TC_COUNT_RESET 16'h0000

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define TC_OVF_BIT     7
`define TC_EXT_BIT     6
`define TC_RXSEL_BIT   5
`define TC_TXSEL_BIT   4
`define TC_TRGEN_BIT   3
`define TC_RUN_BIT     2
`define TC_CSEL_BIT    1
`define TC_CAPSEL_BIT  0

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define TC_CLKOUT_BIT  1
`define TC_UPDN_BIT    0

// ----------------------------------------------------------------
// Counting rates and limits
// ----------------------------------------------------------------
`define TC_TIMER_DIV   3'h6
`define TC_FAST_DIV    3'h2
`define TC_COUNT_MAX   16'hFFFF

`endif

// *** design/tc_pkg.sv ***
`include "tc_defs.svh"

package tc_pkg;

  typedef enum logic [1:0] {TC_CAPTURE, TC_RELOAD, TC_UPDOWN, TC_BAUD} tc_mode_type;

  // Baud use overrides capture, and capture overrides up/down counting
  function automatic tc_mode_type tc_decode_mode(input logic [7:0] ctrl, input logic [1:0] mode_bits);
    tc_mode_type m;
    m = TC_RELOAD;
    if (ctrl[`TC_RXSEL_BIT] || ctrl[`TC_TXSEL_BIT])
      m = TC_BAUD;
    else if (ctrl[`TC_CAPSEL_BIT])
      m = TC_CAPTURE;
    else if (mode_bits[`TC_UPDN_BIT])
      m = TC_UPDOWN;
    return m;
  endfunction

endpackage

// *** design/tc_tick_if.sv ***
`timescale 1ns/1ns

interface tc_tick_if;
  logic tick;
  logic trig_fall;
  logic counter_select;
  logic fast;

  modport gen
  (
    input  counter_select,
    input  fast,
    output tick,
    output trig_fall
  );

  modport core
  (
    output counter_select,
    output fast,
    input  tick,
    input  trig_fall
  );
endinterface

// *** design/tc_tick_gen.sv ***
`timescale 1ns/1ns
`include "tc_defs.svh"

module tc_tick_gen
  import tc_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  tc_tick_if.gen    evt,
  input  wire logic external_count_pin_i,
  input  wire logic trigger_direction_pin_i
);

  logic [2:0] prescale;
  logic [2:0] div_last;
  logic       pin_q;
  logic       trig_q;

  assign div_last = evt.fast ? (`TC_FAST_DIV - 3'h1) : (`TC_TIMER_DIV - 3'h1);

  // ----------------------------------------------------------------
  // Internal divider
  // ----------------------------------------------------------------
  // Greater-or-equal guards a switch from the slow to the fast rate
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      prescale <= 3'h0;
    else if (prescale >= div_last)
      prescale <= 3'h0;
    else
      prescale <= prescale + 3'h1;
  end

  // ----------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pin_q  <= 1'b0;
      trig_q <= 1'b0;
    end
    else
    begin
      pin_q  <= external_count_pin_i;
      trig_q <= trigger_direction_pin_i;
    end
  end

  assign evt.tick      = evt.counter_select ? (pin_q & ~external_count_pin_i) : (prescale >= div_last);
  assign evt.trig_fall = trig_q & ~trigger_direction_pin_i;

endmodule

// *** design/tc_clk_out.sv ***
`timescale 1ns/1ns

module tc_clk_out
(
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic enable_i,
  input  wire logic toggle_i,
  output logic      pin_o
);

  // Held low while disabled so the pin starts from a known phase
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      pin_o <= 1'b0;
    else if (!enable_i)
      pin_o <= 1'b0;
    else if (toggle_i)
      pin_o <= ~pin_o;
  end

endmodule

// *** verif/tc_pin_model.sv ***
`timescale 1ns/1ns

// Far side of the timer: count pin, trigger/direction pin, other timer overflow
module tc_pin_model
(
  input  wire logic clock_i,
  input  wire logic pin_oe_i,
  input  wire logic pin_drv_i,
  output logic      count_pin_o,
  output logic      trig_pin_o,
  output logic      timer1_ovf_o
);
  logic       own_level;
  logic [2:0] t1_div;

  // Port pin has a pull-up, so the count pin rests high when nobody pulls it
  assign count_pin_o = pin_oe_i ? pin_drv_i : own_level;

  initial
  begin
    own_level    = 1'b1;
    trig_pin_o   = 1'b1;
    t1_div       = 3'h0;
    timer1_ovf_o = 1'b0;
  end

  // Other timer overflows once every eight clocks
  always @(negedge clock_i)
  begin
    t1_div       <= t1_div + 3'h1;
    timer1_ovf_o <= (t1_div == 3'h6);
  end

  task automatic count_edges(input int n);
    repeat (n)
    begin
      @(negedge clock_i);
      own_level = 1'b0;
      repeat (2) @(negedge clock_i);
      own_level = 1'b1;
      repeat (2) @(negedge clock_i);
    end
  endtask

  task automatic trig_fall();
    @(negedge clock_i);
    trig_pin_o = 1'b0;
    repeat (3) @(negedge clock_i);
    trig_pin_o = 1'b1;
  endtask

  task automatic set_dir(input logic up);
    @(negedge clock_i);
    trig_pin_o = up;
  endtask
endmodule

// *** verif/timer2_control_and_mode_tb_top.sv ***
`timescale 1ns/1ns
`include "tc_defs.svh"

module timer2_control_and_mode_tb_top;
  logic        clock_i;
  logic        sys_rst_i;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        bit_wr;
  logic [7:0]  bit_addr;
  logic        bit_val;
  logic        cnt_pin;
  logic        pin_drv;
  logic        pin_oe;
  logic        trig_pin;
  logic        cnt_lo_wr;
  logic [7:0]  cnt_lo_wdata;
  logic [7:0]  count_low;
  logic        capture;
  logic        timer_ovf;
  logic        t1_ovf;
  logic        rx_clk;
  logic        tx_clk;
  logic        irq;
  logic [7:0]  held;
  logic [15:0] cap_val;
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;

  tc_core dut
  (
    .clock_i                 (clock_i),
    .sys_rst_i               (sys_rst_i),
    .sfr_addr_i              (sfr_addr),
    .sfr_wr_i                (sfr_wr),
    .sfr_rd_i                (sfr_rd),
    .sfr_wdata_i             (sfr_wdata),
    .sfr_rdata_o             (sfr_rdata),
    .bit_wr_i                (bit_wr),
    .bit_addr_i              (bit_addr),
    .bit_val_i               (bit_val),
    .external_count_pin_i    (cnt_pin),
    .external_count_pin_o    (pin_drv),
    .external_count_pin_oe_o (pin_oe),
    .trigger_direction_pin_i (trig_pin),
    .reload_value_i          (16'h1234),
    .count_low_wr_i          (cnt_lo_wr),
    .count_low_wdata_i       (cnt_lo_wdata),
    .count_low_o             (count_low),
    .capture_o               (capture),
    .capture_value_o         (cap_val),
    .timer_ovf_o             (timer_ovf),
    .timer1_ovf_i            (t1_ovf),
    .rx_baud_clk_o           (rx_clk),
    .tx_baud_clk_o           (tx_clk),
    .timer_irq_o             (irq)
  );

  tc_pin_model model
  (
    .clock_i      (clock_i),
    .pin_oe_i     (pin_oe),
    .pin_drv_i    (pin_drv),
    .count_pin_o  (cnt_pin),
    .trig_pin_o   (trig_pin),
    .timer1_ovf_o (t1_ovf)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Whole run needs about 350 cycles; the ceiling leaves ample margin
  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails = fails + 1;
      $display("BAD %0t run hung", $time);
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clock_i);
    sfr_wr    = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask, input string what);
    @(negedge clock_i);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clock_i);
    sfr_rd   = 1'b0;
    chk({8'h00, sfr_rdata & mask}, {8'h00, exp}, what);
  endtask

  task automatic bw(input logic [2:0] b, input logic v);
    @(negedge clock_i);
    bit_addr = `TC_BIT_BASE + {5'h00, b};
    bit_val  = v;
    bit_wr   = 1'b1;
    @(negedge clock_i);
    bit_wr   = 1'b0;
  endtask

  // Loads the whole 16-bit count: high byte over the bus, low byte directly
  task automatic load(input logic [15:0] c);
    wr(`TC_CNTH_ADDR, c[15:8]);
    cnt_lo_wdata = c[7:0];
    cnt_lo_wr    = 1'b1;
    @(negedge clock_i);
    cnt_lo_wr    = 1'b0;
  endtask

  task automatic wait_for(input logic cap, input int lim, input string what);
    int k;
    k = 0;
    while (k < lim && ((cap ? capture : timer_ovf) !== 1'b1))
    begin
      @(negedge clock_i);
      k++;
    end
    chk({15'h0000, k < lim}, 16'h0001, what);
  endtask

  initial
  begin
    {sfr_addr, sfr_wr, sfr_rd, sfr_wdata, bit_wr, bit_addr, bit_val} = '0;
    {cnt_lo_wr, cnt_lo_wdata} = '0;
    sys_rst_i = 1'b1;
    repeat (5) @(negedge clock_i);
    sys_rst_i = 1'b0;

    rd(`TC_CTRL_ADDR, 8'h00, 8'hff, "ctrl reset");
    rd(`TC_MODE_ADDR, 8'h00, 8'h03, "mode reset");
    rd(`TC_CNTH_ADDR, 8'h00, 8'hff, "high reset");
    rd(8'hc0, 8'h00, 8'hff, "unmapped");
    wr(`TC_CNTH_ADDR, 8'ha5);
    rd(`TC_CNTH_ADDR, 8'ha5, 8'hff, "high rw");
    bw(`TC_TRGEN_BIT, 1'b1);
    rd(`TC_CTRL_ADDR, 8'h08, 8'hff, "bit set");
    bw(`TC_TRGEN_BIT, 1'b0);
    rd(`TC_CTRL_ADDR, 8'h00, 8'hff, "bit clear");
    wr(`TC_MODE_ADDR, 8'h01);
    rd(`TC_MODE_ADDR, 8'h01, 8'h03, "mode rw");
    wr(`TC_MODE_ADDR, 8'h00);
    $display("test registers done");

    load(16'h1200);
    repeat (30) @(negedge clock_i);
    chk(count_low, 8'h00, "stopped");
    bw(`TC_RUN_BIT, 1'b1);
    repeat (60) @(negedge clock_i);
    bw(`TC_RUN_BIT, 1'b0);
    held = count_low;
    chk({15'h0000, held >= 8'h0a && held <= 8'h0b}, 16'h0001, "div six rate");
    repeat (20) @(negedge clock_i);
    chk(count_low, held, "held");
    $display("test run done");

    load(16'hfffe);
    bw(`TC_RUN_BIT, 1'b1);
    wait_for(1'b0, 30, "overflow");
    chk(count_low, 8'h34, "reload low");
    chk(irq, 1'b1, "irq on flag");
    bw(`TC_RUN_BIT, 1'b0);
    rd(`TC_CNTH_ADDR, 8'h12, 8'hff, "reload high");
    repeat (20) @(negedge clock_i);
    rd(`TC_CTRL_ADDR, 8'h80, 8'h80, "flag sticks");
    bw(`TC_OVF_BIT, 1'b0);
    rd(`TC_CTRL_ADDR, 8'h00, 8'h80, "flag clear");
    $display("test overflow done");

    load(16'hfffe);
    wr(`TC_CTRL_ADDR, 8'h14);
    wait_for(1'b0, 30, "baud overflow");
    chk(tx_clk, 1'b1, "tx own");
    chk(rx_clk, t1_ovf, "rx other");
    rd(`TC_CTRL_ADDR, 8'h00, 8'h80, "no flag baud");
    wr(`TC_CTRL_ADDR, 8'h00);
    $display("test baud done");

    // Counter stopped, so the captured value is the loaded one
    load(16'h00a7);
    wr(`TC_CTRL_ADDR, 8'h09);
    fork
      model.trig_fall();
      wait_for(1'b1, 10, "capture");
    join
    chk(cap_val, 16'h00a7, "capture value");
    rd(`TC_CTRL_ADDR, 8'h40, 8'h40, "event flag");
    chk(irq, 1'b1, "irq on event");
    wr(`TC_CTRL_ADDR, 8'h05);
    model.trig_fall();
    rd(`TC_CTRL_ADDR, 8'h00, 8'h40, "trigger ignored");
    wr(`TC_CTRL_ADDR, 8'h0c);
    model.trig_fall();
    wr(`TC_CTRL_ADDR, 8'h00);
    rd(`TC_CNTH_ADDR, 8'h12, 8'hff, "trigger reload");
    $display("test trigger done");

    wr(`TC_MODE_ADDR, 8'h01);
    load(16'h5000);
    model.set_dir(1'b0);
    bw(`TC_RUN_BIT, 1'b1);
    repeat (30) @(negedge clock_i);
    bw(`TC_RUN_BIT, 1'b0);
    rd(`TC_CNTH_ADDR, 8'h4f, 8'hff, "down count");
    model.set_dir(1'b1);
    $display("test updown done");

    wr(`TC_MODE_ADDR, 8'h02);
    chk(pin_oe, 1'b1, "clock out on");
    load(16'hfffe);
    bw(`TC_RUN_BIT, 1'b1);
    wait_for(1'b0, 30, "clkout overflow");
    chk(pin_drv, 1'b1, "clock toggled");
    bw(`TC_RUN_BIT, 1'b0);
    wr(`TC_MODE_ADDR, 8'h00);
    chk(pin_oe, 1'b0, "clock out off");
    $display("test clock out done");

    load(16'h0000);
    wr(`TC_CTRL_ADDR, 8'h06);
    model.count_edges(5);
    repeat (3) @(negedge clock_i);
    chk(count_low, 8'h05, "pin edges");
    $display("test count pin done");
    final_report();
  end
endmodule
